// ===== common/timer_defines.vh
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// register byte offsets
`define OFS_CTRL 6'h00
`define OFS_PRESC 6'h04
`define OFS_TOP 6'h08
`define OFS_COMPARE 6'h0C
`define OFS_RELOAD 6'h10
`define OFS_COUNT 6'h14
`define OFS_CAPTURE 6'h18
`define OFS_IRQ_STATUS 6'h1C
`define OFS_IRQ_CLEAR 6'h20
`define OFS_IRQ_ENABLE 6'h24

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_ENABLE_BIT 2
`define CTRL_CAPEN_BIT 3
`define CTRL_RELOAD_BIT 4
`define CTRL_CLKSEL_BIT 5
`define CTRL_RSTEN_BIT 6

// operating modes
`define MODE_WDOG 2'h0
`define MODE_CTC 2'h1
`define MODE_FPWM 2'h2
`define MODE_PFC 2'h3

// interrupt status / enable bit positions
`define IRQ_OVF_BIT 0
`define IRQ_CMP_BIT 1
`define IRQ_CAP_BIT 2
`define IRQ_WAKE_LSB 4

// reset values
`define RST_CTRL 7'h44
`define RST_PRESC 16'h0000
`define RST_TOP 16'hFFFF
`define RST_COMPARE 16'h8000
`define RST_RELOAD 16'h0000
`define RST_IRQ_ENABLE 7'h00

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/timer_prescaler.v
`timescale 1ns/100ps
// divides the selected source ticks by (divisor + 1)
module timer_prescaler #(
   parameter W = 16
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   input wire ce,
   // control
   input wire restart,
   input wire src_tick,
   input wire [W-1:0] divisor,
   // result
   output reg tick
);
   reg [W-1:0] div_cnt_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= {W{1'b0}};
         tick <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (restart) begin
            div_cnt_r <= {W{1'b0}};
         end else if (src_tick) begin
            if (div_cnt_r >= divisor) begin
               div_cnt_r <= {W{1'b0}};
               tick <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// ===== src/hard_timer_counter_pwm.v
`timescale 1ns/100ps
// Behaviour
// - one 16-bit counter that counts up or down by mode
// - modes: watchdog, clear on compare match, fast PWM, phase-frequency correct PWM
// - three interrupt sources: overflow, compare match, input capture
// - capture input synchronised; rising edge stores count when enabled, non-PWM, bus mode
// - irq is bare overflow flag standalone, else status, enable and clear registers
// - counter clock source selectable and divided by programmable prescaler
// - one static interrupt output and one separate wake-up interrupt output
// - registers read and written by the fabric through a bus slave port
// - standalone mode: preloaded control values, counter reset straight from reset pin
// - reset pin enable is preloaded on so the reset pin always acts
// - PWM output glitch-free; while counting, period and duty change only at cycle boundary
// - one compare unit independent of capture drives the waveform output
`include "timer_defines.vh"
module hard_timer_counter_pwm #(
   parameter W = 16,
   parameter STANDALONE = 0,
   parameter [6:0] PRE_CTRL = `RST_CTRL,
   parameter [15:0] PRE_PRESC = `RST_PRESC,
   parameter [15:0] PRE_TOP = `RST_TOP,
   parameter [15:0] PRE_COMPARE = `RST_COMPARE,
   parameter [15:0] PRE_RELOAD = `RST_RELOAD
) (
   // clock, reset, clock enable
   input wire CLK,
   input wire RST_N,
   input wire CE,
   // timer pins
   input wire TIMER_INPUT_CLOCK,
   input wire TIMER_RESET_PIN_N,
   input wire CAPTURE_TRIGGER_IN,
   output reg COMPARE_WAVEFORM_OUT,
   output reg TIMER_IRQ_OUT,
   output reg WAKE_IRQ_OUT,
   // AXI4-Lite write
   input wire [5:0] AWADDR,
   input wire AWVALID,
   output reg AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output reg WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   // AXI4-Lite read
   input wire [5:0] ARADDR,
   input wire ARVALID,
   output reg ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY
);
   function [31:0] merge;
      input [31:0] old;
      input [31:0] upd;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = strb[i] ? upd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   function mapped;
      input [5:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `OFS_IRQ_ENABLE);
      end
   endfunction

   // registers
   reg [6:0] ctrl_r;
   reg [15:0] presc_r;
   reg [W-1:0] top_r, cmp_r, reload_r, count_r, capture_r;
   reg [W-1:0] top_b_r, cmp_b_r;
   reg dir_r;
   reg [2:0] status_r;
   reg [6:0] irq_en_r;
   // bus state
   reg aw_held_r, w_held_r;
   reg [5:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   // input edge detectors
   reg clk_in_d_r;
   reg cap_s1_r, cap_s2_r, cap_s3_r;

   wire [1:0] mode = ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   wire enable = ctrl_r[`CTRL_ENABLE_BIT];
   wire pwm_mode = (mode == `MODE_FPWM) || (mode == `MODE_PFC);
   wire do_write = aw_held_r && w_held_r && !BVALID;
   wire wr_ok = do_write && mapped(awaddr_r) && (STANDALONE == 0);
   wire [31:0] wr_old = (awaddr_r == `OFS_CTRL) ? {25'h0, ctrl_r} :
                        (awaddr_r == `OFS_PRESC) ? {16'h0, presc_r} :
                        (awaddr_r == `OFS_TOP) ? {{(32-W){1'b0}}, top_r} :
                        (awaddr_r == `OFS_COMPARE) ? {{(32-W){1'b0}}, cmp_r} :
                        (awaddr_r == `OFS_RELOAD) ? {{(32-W){1'b0}}, reload_r} :
                        (awaddr_r == `OFS_COUNT) ? {{(32-W){1'b0}}, count_r} :
                        (awaddr_r == `OFS_IRQ_ENABLE) ? {25'h0, irq_en_r} : 32'h00000000;
   wire [31:0] wr_val = merge(wr_old, wdata_r, wstrb_r);
   wire wr_count = wr_ok && (awaddr_r == `OFS_COUNT);

   // reset pin is honoured whatever else is set
   wire pin_reset = ctrl_r[`CTRL_RSTEN_BIT] && !TIMER_RESET_PIN_N;

   // clock source: system clock or rising edge of the timer input clock
   wire ext_edge = TIMER_INPUT_CLOCK && !clk_in_d_r;
   wire src_tick = enable && (ctrl_r[`CTRL_CLKSEL_BIT] ? ext_edge : 1'b1);
   wire tick;

   timer_prescaler #(.W(16)) u_presc (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .restart(pin_reset || !enable),
      .src_tick(src_tick),
      .divisor(presc_r),
      .tick(tick)
   );

   // counter next state
   reg [W-1:0] cnt_nxt;
   reg dir_nxt, ovf_ev, cmp_ev, bound_ev;
   wire [W-1:0] wrap_val = ctrl_r[`CTRL_RELOAD_BIT] ? reload_r : {W{1'b0}};
   wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

   always @* begin
      cnt_nxt = count_r;
      dir_nxt = dir_r;
      ovf_ev = 1'b0;
      cmp_ev = 1'b0;
      bound_ev = 1'b0;
      if (tick) begin
         cmp_ev = (count_r == cmp_b_r);
         case (mode)
            `MODE_WDOG: begin
               dir_nxt = 1'b0;
               if (count_r == top_b_r) begin
                  ovf_ev = 1'b1;
                  cnt_nxt = wrap_val;
               end else begin
                  cnt_nxt = count_r + one;
               end
            end
            `MODE_CTC: begin
               dir_nxt = 1'b0;
               if (count_r == cmp_b_r) begin
                  cnt_nxt = {W{1'b0}};
               end else begin
                  cnt_nxt = count_r + one;
               end
               if (count_r == {W{1'b1}}) begin
                  ovf_ev = 1'b1;
                  cnt_nxt = wrap_val;
               end
            end
            `MODE_FPWM: begin
               dir_nxt = 1'b0;
               if (count_r == top_b_r) begin
                  ovf_ev = 1'b1;
                  bound_ev = 1'b1;
                  cnt_nxt = wrap_val;
               end else begin
                  cnt_nxt = count_r + one;
               end
            end
            `MODE_PFC: begin
               if (!dir_r) begin
                  if (count_r >= top_b_r) begin
                     dir_nxt = 1'b1;
                     cnt_nxt = count_r - one;
                  end else begin
                     cnt_nxt = count_r + one;
                  end
               end else if (count_r == {W{1'b0}}) begin
                  ovf_ev = 1'b1;
                  bound_ev = 1'b1;
                  dir_nxt = 1'b0;
                  cnt_nxt = one;
               end else begin
                  cnt_nxt = count_r - one;
               end
            end
            default: begin
               cnt_nxt = count_r;
            end
         endcase
      end
   end

   // waveform next value: PWM modes compare the count it is about to hold, clear on compare match toggles on a match of the current count
   reg wave_nxt;
   always @* begin
      case (mode)
         `MODE_CTC: wave_nxt = cmp_ev ? ~COMPARE_WAVEFORM_OUT : COMPARE_WAVEFORM_OUT;
         `MODE_FPWM: wave_nxt = (cnt_nxt < cmp_b_r);
         `MODE_PFC: wave_nxt = (cnt_nxt < cmp_b_r);
         default: wave_nxt = 1'b0;
      endcase
   end

   wire cap_rise = cap_s2_r && !cap_s3_r;
   wire cap_ev = cap_rise && ctrl_r[`CTRL_CAPEN_BIT] && !pwm_mode
                 && (STANDALONE == 0);
   wire [2:0] set_ev = {cap_ev, cmp_ev, ovf_ev};
   wire [2:0] clr_ev = (wr_ok && (awaddr_r == `OFS_IRQ_CLEAR)) ?
                       (wdata_r[2:0] & {3{wstrb_r[0]}}) : 3'h0;
   wire [2:0] status_nxt = (status_r & ~clr_ev) | set_ev;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r <= PRE_CTRL | 7'h40;
         presc_r <= PRE_PRESC;
         top_r <= PRE_TOP[W-1:0];
         cmp_r <= PRE_COMPARE[W-1:0];
         reload_r <= PRE_RELOAD[W-1:0];
         top_b_r <= PRE_TOP[W-1:0];
         cmp_b_r <= PRE_COMPARE[W-1:0];
         count_r <= {W{1'b0}};
         dir_r <= 1'b0;
         capture_r <= {W{1'b0}};
         status_r <= 3'h0;
         irq_en_r <= `RST_IRQ_ENABLE;
         clk_in_d_r <= 1'b0;
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_s3_r <= 1'b0;
         COMPARE_WAVEFORM_OUT <= 1'b0;
         TIMER_IRQ_OUT <= 1'b0;
         WAKE_IRQ_OUT <= 1'b0;
      end else if (CE) begin
         clk_in_d_r <= TIMER_INPUT_CLOCK;
         cap_s1_r <= CAPTURE_TRIGGER_IN;
         cap_s2_r <= cap_s1_r;
         cap_s3_r <= cap_s2_r;
         if (wr_ok) begin
            case (awaddr_r)
               `OFS_CTRL: ctrl_r <= wr_val[6:0] | 7'h40;
               `OFS_PRESC: presc_r <= wr_val[15:0];
               `OFS_TOP: top_r <= wr_val[W-1:0];
               `OFS_COMPARE: cmp_r <= wr_val[W-1:0];
               `OFS_RELOAD: reload_r <= wr_val[W-1:0];
               `OFS_IRQ_ENABLE: irq_en_r <= wr_val[6:0];
               default: irq_en_r <= irq_en_r;
            endcase
         end
         // buffered period and duty change only at a cycle boundary in PWM modes while enabled
         if (!pwm_mode || bound_ev || !enable) begin
            top_b_r <= top_r;
            cmp_b_r <= cmp_r;
         end
         if (pin_reset) begin
            count_r <= {W{1'b0}};
            dir_r <= 1'b0;
         end else if (wr_count) begin
            count_r <= wr_val[W-1:0];
         end else begin
            count_r <= cnt_nxt;
            dir_r <= dir_nxt;
         end
         if (cap_ev) begin
            capture_r <= count_r;
         end
         status_r <= status_nxt;
         if (STANDALONE != 0) begin
            TIMER_IRQ_OUT <= status_nxt[`IRQ_OVF_BIT];
         end else begin
            TIMER_IRQ_OUT <= |(status_nxt & irq_en_r[2:0]);
         end
         WAKE_IRQ_OUT <= |(status_nxt & irq_en_r[`IRQ_WAKE_LSB +: 3]);
         COMPARE_WAVEFORM_OUT <= pin_reset ? 1'b0 : wave_nxt;
      end
   end

   // AXI4-Lite write channel
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 6'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= `RESP_OKAY;
      end else if (CE) begin
         if (AWVALID && AWREADY) begin
            aw_held_r <= 1'b1;
            awaddr_r <= AWADDR;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_held_r <= 1'b1;
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
            WREADY <= 1'b0;
         end
         if (do_write) begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel
   reg [31:0] rd_val;
   always @* begin
      case (ARADDR)
         `OFS_CTRL: rd_val = {25'h0, ctrl_r};
         `OFS_PRESC: rd_val = {16'h0, presc_r};
         `OFS_TOP: rd_val = {{(32-W){1'b0}}, top_r};
         `OFS_COMPARE: rd_val = {{(32-W){1'b0}}, cmp_r};
         `OFS_RELOAD: rd_val = {{(32-W){1'b0}}, reload_r};
         `OFS_COUNT: rd_val = {{(32-W){1'b0}}, count_r};
         `OFS_CAPTURE: rd_val = {{(32-W){1'b0}}, capture_r};
         `OFS_IRQ_STATUS: rd_val = {29'h0, status_r};
         `OFS_IRQ_ENABLE: rd_val = {25'h0, irq_en_r};
         default: rd_val = 32'h00000000;
      endcase
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= `RESP_OKAY;
      end else if (CE) begin
         if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_val;
            RRESP <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end
endmodule

// ===== sim/timer_sva.sv
`timescale 1ns/100ps
module timer_checker (
   // clock and reset
   input logic CLK,
   input logic RST_N,
   input logic CE,
   // timer pins
   input logic TIMER_RESET_PIN_N,
   input logic COMPARE_WAVEFORM_OUT,
   input logic TIMER_IRQ_OUT,
   input logic WAKE_IRQ_OUT,
   // bus handshakes
   input logic AWVALID,
   input logic AWREADY,
   input logic WVALID,
   input logic WREADY,
   input logic BVALID,
   input logic BREADY,
   input logic ARVALID,
   input logic ARREADY,
   input logic RVALID,
   input logic RREADY,
   input logic [31:0] RDATA
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_b_after_both: assert property (AWVALID && AWREADY && WVALID && WREADY && CE |-> ##2 BVALID)
      else $error("write answer missing");
   a_b_holds: assert property (BVALID && !(BREADY && CE) |=> BVALID)
      else $error("write answer dropped");
   a_aw_blocked: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write accepted while answer pending");
   a_r_after_ar: assert property (ARVALID && ARREADY && CE |=> RVALID && !ARREADY)
      else $error("read answer missing");
   a_r_steady: assert property (RVALID && !(RREADY && CE) |=> RVALID && $stable(RDATA))
      else $error("read data changed while pending");
   a_r_cause: assert property ($rose(RVALID) |-> $past(ARVALID && ARREADY))
      else $error("read answer without request");
   a_irq_sticky: assert property ($fell(TIMER_IRQ_OUT) |-> BVALID || $past(BVALID))
      else $error("irq dropped without a write");
   a_wake_sticky: assert property ($fell(WAKE_IRQ_OUT) |-> BVALID || $past(BVALID))
      else $error("wake irq dropped without a write");
   a_pin_quiet: assert property (!TIMER_RESET_PIN_N && CE |=> !COMPARE_WAVEFORM_OUT)
      else $error("waveform high while reset pin low");

   c_write: cover property (BVALID && BREADY);
   c_read: cover property (RVALID && RREADY);
   c_irq: cover property ($rose(TIMER_IRQ_OUT));
endmodule

bind hard_timer_counter_pwm timer_checker chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
   .TIMER_RESET_PIN_N(TIMER_RESET_PIN_N), .COMPARE_WAVEFORM_OUT(COMPARE_WAVEFORM_OUT),
   .TIMER_IRQ_OUT(TIMER_IRQ_OUT), .WAKE_IRQ_OUT(WAKE_IRQ_OUT), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));

// ===== sim/fabric_master.sv
`timescale 1ns/100ps
module fabric_master (
   // clock
   input logic clk,
   // write side
   output logic [5:0] awaddr,
   output logic awvalid,
   input logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input logic wready,
   input logic [1:0] bresp,
   input logic bvalid,
   output logic bready,
   // read side
   output logic [5:0] araddr,
   output logic arvalid,
   input logic arready,
   input logic [31:0] rdata,
   input logic [1:0] rresp,
   input logic rvalid,
   output logic rready
);
   bit hang = 0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // both channels offered together, each released once taken
   task wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      n = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 200);
      r = bresp;
      bready <= 1'b0;
      if (n >= 200) hang = 1;
   endtask
   task rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      n = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 200);
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
      if (n >= 200) hang = 1;
   endtask
endmodule

// ===== sim/hard_timer_counter_pwm_tb_top.sv
`timescale 1ns/100ps
`include "timer_defines.vh"
module hard_timer_counter_pwm_tb_top;
   logic clk = 0, rst_n = 0, ce = 1, tclk = 0, pin_n = 1, trig = 0;
   logic wave, irq, wake, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int errors = 0, n_compared = 0;
   always #4 clk = ~clk;
   always @(posedge clk) tclk <= ~tclk;
   hard_timer_counter_pwm dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .TIMER_INPUT_CLOCK(tclk),
      .TIMER_RESET_PIN_N(pin_n), .CAPTURE_TRIGGER_IN(trig), .COMPARE_WAVEFORM_OUT(wave),
      .TIMER_IRQ_OUT(irq), .WAKE_IRQ_OUT(wake), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   fabric_master m (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      errors += m.hang;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge m.hang) finish_test();
   task automatic t_regs;
      logic [5:0] a [5] = '{`OFS_CTRL, `OFS_TOP, `OFS_COMPARE, `OFS_IRQ_ENABLE, 6'h28};
      logic [31:0] e [5] = '{32'h44, 32'hFFFF, 32'h8000, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         m.rd(a[i], v, r);
         chk("reset value", v, e[i]);
         chk("read answer", r, i == 4 ? `RESP_SLVERR : `RESP_OKAY);
      end
      m.wr(`OFS_CTRL, 32'h0, r);
      m.rd(`OFS_CTRL, v, r);
      chk("reset pin enable", v, 32'h40);
      m.wr(6'h2C, 32'h1, r);
      chk("unmapped write", r, `RESP_SLVERR);
      $display("registers test done");
   endtask
   task t_ovf;
      int n;
      m.wr(`OFS_TOP, 4, r);
      m.wr(`OFS_RELOAD, 2, r);
      m.wr(`OFS_COUNT, 0, r);
      m.wr(`OFS_IRQ_CLEAR, 7, r);
      m.wr(`OFS_IRQ_ENABLE, 32'h11, r);
      chk("irq idle", irq, 0);
      m.wr(`OFS_CTRL, 32'h14, r);
      for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk);
      chk("overflow irq", irq, 1);
      if (n == 50) finish_test();
      chk("wake irq", wake, 1);
      m.wr(`OFS_CTRL, 32'h10, r);
      m.rd(`OFS_COUNT, v, r);
      chk("reloaded count", v >= 2 && v <= 4, 1);
      repeat (5) @(posedge clk);
      chk("sticky irq", irq, 1);
      m.wr(`OFS_IRQ_ENABLE, 32'h10, r);
      @(posedge clk);
      chk("masked irq", irq, 0);
      m.rd(`OFS_IRQ_STATUS, v, r);
      chk("overflow flag", v[0], 1);
      m.wr(`OFS_IRQ_CLEAR, 1, r);
      @(posedge clk);
      chk("cleared wake", wake, 0);
      $display("overflow test done");
   endtask
   task pulse;
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task t_cap;
      m.wr(`OFS_CTRL, 32'h08, r);
      m.wr(`OFS_COUNT, 32'h1234, r);
      pulse();
      m.rd(`OFS_CAPTURE, v, r);
      chk("capture", v, 32'h1234);
      m.rd(`OFS_IRQ_STATUS, v, r);
      chk("capture flag", v[2], 1);
      m.wr(`OFS_CTRL, 32'h0A, r);
      m.wr(`OFS_COUNT, 32'h55, r);
      pulse();
      m.rd(`OFS_CAPTURE, v, r);
      chk("no capture in pwm", v, 32'h1234);
      $display("capture test done");
   endtask
   task automatic t_wave;
      logic [31:0] c [5] = '{32'h06, 32'h05, 32'h05, 32'h25, 32'h07};
      logic [31:0] p [5] = '{0, 0, 1, 0, 0};
      int e [5] = '{40, 20, 10, 10, 35};
      int hi, tg;
      logic last;
      m.wr(`OFS_TOP, 9, r);
      m.wr(`OFS_COMPARE, 4, r);
      m.wr(`OFS_RELOAD, 0, r);
      for (int i = 0; i < 5; i++) begin
         m.wr(`OFS_CTRL, 0, r);
         m.wr(`OFS_PRESC, p[i], r);
         m.wr(`OFS_COUNT, 0, r);
         m.wr(`OFS_CTRL, c[i], r);
         repeat (40) @(posedge clk);
         {hi, tg, last} = {32'd0, 32'd0, wave};
         repeat (100) begin
            @(posedge clk);
            hi += wave;
            tg += (wave !== last);
            last = wave;
         end
         chk("waveform", (i == 0 || i == 4) ? hi : tg, e[i]);
      end
      // phase-frequency correct run keeps going: a low clock enable must hold the output
      ce <= 1'b0;
      @(posedge clk);
      {tg, last} = {32'd0, wave};
      repeat (20) begin
         @(posedge clk);
         tg += (wave !== last);
      end
      ce <= 1'b1;
      chk("frozen by clock enable", tg, 0);
      pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("wave in pin reset", wave, 0);
      m.rd(`OFS_COUNT, v, r);
      chk("count in pin reset", v, 0);
      pin_n <= 1'b1;
      $display("waveform test done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_ovf();
      t_cap();
      t_wave();
      finish_test();
   end
endmodule
